// *** logic/wdrt_pkg.sv ***
`default_nettype none

package wdrt_pkg;

  // ----------------------------------------------------------------
  // Register map (printed offsets are word indices, byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [31:0] RELOAD_HIGH_INDEX = 32'h00FFE042;
  localparam logic [31:0] RELOAD_LOW_INDEX  = 32'h00FFE043;
  localparam logic [31:0] STATUS_INDEX      = 32'h00FFE044;

  // ----------------------------------------------------------------
  // Reset values and keys
  // ----------------------------------------------------------------
  localparam logic [7:0]  RELOAD_HIGH_RESET = 8'h04;
  localparam logic [7:0]  RELOAD_LOW_RESET  = 8'h00;
  localparam logic [15:0] COUNT_RESET       = {RELOAD_HIGH_RESET, RELOAD_LOW_RESET};
  localparam logic [15:0] COUNT_LAST        = 16'h0001;
  localparam logic [15:0] RELOAD_MINIMUM    = 16'h0004;
  localparam logic [7:0]  UNLOCK_KEY_FIRST  = 8'h55;
  localparam logic [7:0]  UNLOCK_KEY_SECOND = 8'hAA;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int STATUS_ENABLED_BIT  = 0;
  localparam int STATUS_UNLOCK_LSB   = 1;
  localparam int STATUS_OSC_BIT      = 3;
  localparam int STATUS_RESPONSE_BIT = 4;

  // ----------------------------------------------------------------
  // Timing: one count per oscillator period, so ms = reload / 10
  // ----------------------------------------------------------------
  localparam int RC_NOMINAL_HZ = 10000;
  localparam int CLK_HZ        = 25000000;
  localparam int CLK_PER_RC    = CLK_HZ / RC_NOMINAL_HZ;
  localparam int SYNC_STAGES   = 2;

  typedef enum logic [1:0] {
    WDRT_LOCKED,
    WDRT_KEY_SEEN,
    WDRT_OPEN_HIGH,
    WDRT_OPEN_LOW
  } wdrt_unlock_t;

  typedef enum logic [1:0] {
    WDRT_SEL_NONE,
    WDRT_SEL_HIGH,
    WDRT_SEL_LOW,
    WDRT_SEL_STATUS
  } wdrt_sel_t;

endpackage

`default_nettype wire

// *** logic/wdrt_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module wdrt_sync
  import wdrt_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] stage1;

  // ----------------------------------------------------------------
  // Two-flop synchroniser; stage1 feeds only the second flop
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stage1 <= '0;
      synced <= '0;
    end else if (ce) begin
      stage1 <= async;
      synced <= stage1;
    end
  end

endmodule

`default_nettype wire

// *** logic/wdrt_tick.sv ***
`timescale 1ns/1ps
`default_nettype none

module wdrt_tick
  import wdrt_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic ce,
  input  wire logic oscLevel,
  input  wire logic oscEnable,
  output logic      tick
);

  logic prevLevel;

  // ----------------------------------------------------------------
  // One tick per oscillator rising edge, none while it is disabled
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prevLevel <= 1'b0;
      tick      <= 1'b0;
    end else if (ce) begin
      prevLevel <= oscLevel;
      tick      <= oscEnable & oscLevel & ~prevLevel;
    end
  end

endmodule

`default_nettype wire

// *** logic/wdrt_top.sv ***
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module wdrt_top
  import wdrt_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rcOscIn,
  input  wire logic        rcOscEnable,
  input  wire logic        alwaysOnOption,
  input  wire logic        timeoutResponseSelect,
  input  wire logic        watchdogRefreshInstruction,
  input  wire logic        onChipDebugger,
  input  wire logic        stopMode,
  output logic             exceptionRequest,
  output logic             resetRequest,
  output logic             stopRecoveryRequest,
  output logic             watchdogFlagSet,
  output logic             stopFlagSet,
  output logic             enabled
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic         oscLevel;
  logic         tick;
  logic [7:0]   reloadHigh;
  logic [7:0]   reloadLow;
  logic [15:0]  reloadValue;
  logic [15:0]  count;
  wdrt_unlock_t unlockState;
  wdrt_sel_t    setupSel;
  wdrt_sel_t    accessSel;
  logic         setupPhase;
  logic         accessDone;
  logic         writeHigh;
  logic         writeLow;
  logic [7:0]   writeByte;
  logic [31:0]  next_prdata;
  logic         enableEvent;
  logic         firstEnable;
  logic         reloadNow;
  logic         timeout;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic wdrt_sel_t decodeAddr(input logic [31:0] addr);
    wdrt_sel_t sel;
    sel = WDRT_SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      if (addr[31:2] == RELOAD_HIGH_INDEX[29:0]) begin
        sel = WDRT_SEL_HIGH;
      end else if (addr[31:2] == RELOAD_LOW_INDEX[29:0]) begin
        sel = WDRT_SEL_LOW;
      end else if (addr[31:2] == STATUS_INDEX[29:0]) begin
        sel = WDRT_SEL_STATUS;
      end
    end
    return sel;
  endfunction

  // Key byte written to the high reload address
  function automatic logic keyWrite(input logic       strobe,
                                    input logic [7:0] value,
                                    input logic [7:0] key);
    return strobe && (value == key);
  endfunction

  // ----------------------------------------------------------------
  // Oscillator edge detection
  // ----------------------------------------------------------------
  wdrt_sync #(
    .WIDTH (1)
  ) u_osc_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    .async   (rcOscIn),
    .synced  (oscLevel)
  );

  wdrt_tick u_tick (
    .clk       (clk),
    .reset_n   (reset_n),
    .ce        (ce),
    .oscLevel  (oscLevel),
    .oscEnable (rcOscEnable),
    .tick      (tick)
  );

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign setupPhase = psel & ~penable;
  assign accessDone = psel & penable & pready;
  assign setupSel   = decodeAddr(paddr);
  assign accessSel  = decodeAddr(paddr);
  assign writeByte  = pwdata[7:0];
  assign writeHigh  = accessDone & pwrite & (accessSel == WDRT_SEL_HIGH);
  assign writeLow   = accessDone & pwrite & (accessSel == WDRT_SEL_LOW);

  // ----------------------------------------------------------------
  // Read data, chosen at the setup edge
  // ----------------------------------------------------------------
  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (setupSel)
      WDRT_SEL_HIGH: begin
        next_prdata[7:0] = count[15:8];
      end
      WDRT_SEL_LOW: begin
        next_prdata[7:0] = count[7:0];
      end
      WDRT_SEL_STATUS: begin
        next_prdata[STATUS_ENABLED_BIT]                  = enabled;
        next_prdata[STATUS_UNLOCK_LSB+1:STATUS_UNLOCK_LSB] = unlockState;
        next_prdata[STATUS_OSC_BIT]                      = rcOscEnable;
        next_prdata[STATUS_RESPONSE_BIT]                 = timeoutResponseSelect;
      end
      WDRT_SEL_NONE: begin
        next_prdata = 32'h0000_0000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Bus answer: one access cycle after every setup
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pready <= 1'b0;
    end else if (ce) begin
      pready <= setupPhase;
    end
  end

  // Unmapped or misaligned addresses answer with an error and no effect
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pslverr <= 1'b0;
    end else if (ce) begin
      pslverr <= setupPhase & (setupSel == WDRT_SEL_NONE);
    end
  end

  // Read data holds until the next setup
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      if (setupPhase) begin
        prdata <= next_prdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Unlock sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      unlockState <= WDRT_LOCKED;
    end else if (ce) begin
      unique case (unlockState)
        WDRT_LOCKED: begin
          if (keyWrite(writeHigh, writeByte, UNLOCK_KEY_FIRST)) begin
            unlockState <= WDRT_KEY_SEEN;
          end
        end
        WDRT_KEY_SEEN: begin
          if (keyWrite(writeHigh, writeByte, UNLOCK_KEY_SECOND)) begin
            unlockState <= WDRT_OPEN_HIGH;
          end else if (writeHigh || writeLow) begin
            unlockState <= WDRT_LOCKED;
          end
        end
        WDRT_OPEN_HIGH: begin
          if (writeHigh) begin
            unlockState <= WDRT_OPEN_LOW;
          end else if (writeLow) begin
            unlockState <= WDRT_LOCKED;
          end
        end
        WDRT_OPEN_LOW: begin
          if (writeLow || writeHigh) begin
            unlockState <= WDRT_LOCKED;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Reload registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reloadHigh <= RELOAD_HIGH_RESET;
    end else if (ce) begin
      // Key writes fall in other states and never reach the byte
      if (writeHigh && unlockState == WDRT_OPEN_HIGH) begin
        reloadHigh <= writeByte;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reloadLow <= RELOAD_LOW_RESET;
    end else if (ce) begin
      if (writeLow && unlockState == WDRT_OPEN_LOW) begin
        reloadLow <= writeByte;
      end
    end
  end

  assign reloadValue = {reloadHigh, reloadLow};

  // ----------------------------------------------------------------
  // Enable
  // ----------------------------------------------------------------
  assign enableEvent = watchdogRefreshInstruction | alwaysOnOption;
  // Of the enabling events, only the first and every refresh instruction load the counter
  assign firstEnable = ~enabled & enableEvent;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      enabled <= 1'b0;
    end else if (ce) begin
      if (enableEvent) begin
        enabled <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Down-counter
  // ----------------------------------------------------------------
  // Debug mode holds the counter at the reload value
  assign reloadNow = firstEnable | watchdogRefreshInstruction | (enabled & onChipDebugger);
  assign timeout   = enabled & tick & ~reloadNow & (count <= COUNT_LAST);

  // ----------------------------------------------------------------
  // Count update: reload wins over time-out, which wins over a tick
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count <= COUNT_RESET;
    end else if (ce) begin
      if (reloadNow) begin
        count <= reloadValue;
      end else if (timeout) begin
        count <= reloadValue;
      end else if (enabled && tick) begin
        count <= count - 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Time-out response: exception in any mode when timeoutResponseSelect is low, reset outside Stop Mode when it is high
  // ----------------------------------------------------------------
  // Pulses follow the time-out edge by one clock and last one cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      exceptionRequest <= 1'b0;
    end else if (ce) begin
      exceptionRequest <= timeout & ~timeoutResponseSelect;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      resetRequest <= 1'b0;
    end else if (ce) begin
      resetRequest <= timeout & timeoutResponseSelect & ~stopMode;
    end
  end

  // ----------------------------------------------------------------
  // Time-out response: Stop Mode recovery and status flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stopRecoveryRequest <= 1'b0;
    end else if (ce) begin
      stopRecoveryRequest <= timeout & stopMode;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      watchdogFlagSet <= 1'b0;
    end else if (ce) begin
      watchdogFlagSet <= timeout & (stopMode | timeoutResponseSelect);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stopFlagSet <= 1'b0;
    end else if (ce) begin
      stopFlagSet <= timeout & stopMode;
    end
  end

endmodule

`default_nettype wire

// *** verification/wdrt_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none

module wdrt_asserts (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rcOscEnable,
  input wire logic watchdogRefreshInstruction,
  input wire logic onChipDebugger,
  input wire logic exceptionRequest,
  input wire logic resetRequest,
  input wire logic stopRecoveryRequest,
  input wire logic watchdogFlagSet,
  input wire logic stopFlagSet,
  input wire logic enabled
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_ready_after_setup: assert property (psel && !penable && ce |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready && ce |=> !pready)
    else $error("pready held too long");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_refresh_enables: assert property (watchdogRefreshInstruction && ce |=> enabled)
    else $error("refresh did not enable");
  a_enable_sticky: assert property (enabled |=> enabled)
    else $error("enable dropped");
  a_off_no_event: assert property (!enabled |-> !exceptionRequest && !resetRequest)
    else $error("event while disabled");
  a_debug_no_event: assert property (onChipDebugger && $past(onChipDebugger) |->
    !(exceptionRequest || resetRequest || stopRecoveryRequest))
    else $error("event in debug mode");
  a_osc_off_quiet: assert property ((!rcOscEnable)[*4] |->
    !(exceptionRequest || resetRequest || stopRecoveryRequest))
    else $error("event with oscillator off");
  a_reset_flags: assert property (resetRequest |->
    watchdogFlagSet && !stopFlagSet && !stopRecoveryRequest)
    else $error("reset response flags wrong");
  a_stop_flags: assert property (stopRecoveryRequest |->
    watchdogFlagSet && stopFlagSet && !resetRequest)
    else $error("stop recovery flags wrong");

  c_exception: cover property (exceptionRequest);
  c_reset: cover property (resetRequest);
  c_stop: cover property (stopRecoveryRequest && stopFlagSet);
endmodule

bind wdrt_top wdrt_asserts chk_u (
  .clk                        (clk),
  .reset_n                    (reset_n),
  .ce                         (ce),
  .psel                       (psel),
  .penable                    (penable),
  .pready                     (pready),
  .pslverr                    (pslverr),
  .rcOscEnable                (rcOscEnable),
  .watchdogRefreshInstruction (watchdogRefreshInstruction),
  .onChipDebugger             (onChipDebugger),
  .exceptionRequest           (exceptionRequest),
  .resetRequest               (resetRequest),
  .stopRecoveryRequest        (stopRecoveryRequest),
  .watchdogFlagSet            (watchdogFlagSet),
  .stopFlagSet                (stopFlagSet),
  .enabled                    (enabled)
);

`default_nettype wire

// *** verification/wdrt_far_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module wdrt_far_model (
  input  wire logic oscOn,
  output logic      rcOscIn
);
  // RC source with a phase unrelated to clk; sits low while disabled
  initial begin
    rcOscIn = 1'b0;
    // Offset keeps every toggle away from a clk edge
    #7;
    forever begin
      #170;
      rcOscIn = oscOn ? !rcOscIn : 1'b0;
    end
  end
endmodule

`default_nettype wire

// *** verification/wdrt_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module wdrt_top_tb import wdrt_pkg::*; ();
  localparam logic [31:0] ADDR_HIGH = {RELOAD_HIGH_INDEX[29:0], 2'b00};
  localparam logic [31:0] ADDR_LOW  = {RELOAD_LOW_INDEX[29:0], 2'b00};
  localparam logic [31:0] ADDR_STAT = {STATUS_INDEX[29:0], 2'b00};
  logic        clk, reset_n, ce, psel, penable, pwrite, pready, pslverr, rcOscIn, rcOscEnable;
  logic        alwaysOnOption, timeoutResponseSelect, watchdogRefreshInstruction;
  logic        onChipDebugger, stopMode, exceptionRequest, resetRequest, stopRecoveryRequest;
  logic        watchdogFlagSet, stopFlagSet, enabled, err;
  logic [31:0] paddr, pwdata, prdata, rdat;
  logic [4:0]  ev;
  logic [4:0]  expEv [4] = '{5'h10, 5'h0A, 5'h17, 5'h07};
  int          failures = 0;
  int          totalChecks = 0;
  int          n;

  wdrt_top dut_u (
    .clk                        (clk),
    .reset_n                    (reset_n),
    .ce                         (ce),
    .psel                       (psel),
    .penable                    (penable),
    .pwrite                     (pwrite),
    .paddr                      (paddr),
    .pwdata                     (pwdata),
    .prdata                     (prdata),
    .pready                     (pready),
    .pslverr                    (pslverr),
    .rcOscIn                    (rcOscIn),
    .rcOscEnable                (rcOscEnable),
    .alwaysOnOption             (alwaysOnOption),
    .timeoutResponseSelect      (timeoutResponseSelect),
    .watchdogRefreshInstruction (watchdogRefreshInstruction),
    .onChipDebugger             (onChipDebugger),
    .stopMode                   (stopMode),
    .exceptionRequest           (exceptionRequest),
    .resetRequest               (resetRequest),
    .stopRecoveryRequest        (stopRecoveryRequest),
    .watchdogFlagSet            (watchdogFlagSet),
    .stopFlagSet                (stopFlagSet),
    .enabled                    (enabled)
  );
  wdrt_far_model osc_u (.oscOn(rcOscEnable), .rcOscIn(rcOscIn));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) failures++;
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask

  task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(what, rdat, exp);
  endtask

  task automatic refresh;
    @(posedge clk);
    watchdogRefreshInstruction <= 1'b1;
    @(posedge clk);
    watchdogRefreshInstruction <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_event;
    ev = 5'h00;
    n = 0;
    while (ev == 5'h00 && n < 400) begin
      @(posedge clk);
      n++;
      ev = {exceptionRequest, resetRequest, stopRecoveryRequest, watchdogFlagSet, stopFlagSet};
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, watchdogRefreshInstruction, onChipDebugger} = 5'h00;
    {stopMode, timeoutResponseSelect, alwaysOnOption, rcOscEnable, reset_n} = 5'h00;
    paddr = 32'h00000000;
    ce = 1'b1;
    pwdata = 32'h00000000;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    rdchk("count high", ADDR_HIGH, 32'h00000004);
    rdchk("count low", ADDR_LOW, 32'h00000000);
    apb(1'b0, 32'h00000010, 32'h00000000);
    check("unmapped error", err, 1'b1);
    check("enabled", enabled, 1'b0);
    $display("test reset done");
    wr(ADDR_HIGH, 8'h12);
    wr(ADDR_LOW, 8'h34);
    refresh;
    check("enabled", enabled, 1'b1);
    rdchk("locked high", ADDR_HIGH, 32'h00000004);
    rdchk("locked low", ADDR_LOW, 32'h00000000);
    $display("test locked done");
    wr(ADDR_HIGH, UNLOCK_KEY_FIRST);
    wr(ADDR_HIGH, UNLOCK_KEY_SECOND);
    wr(ADDR_HIGH, 8'h00);
    wr(ADDR_LOW, 8'h06);
    wr(ADDR_HIGH, 8'h09);
    wr(ADDR_LOW, 8'h09);
    refresh;
    rdchk("unlocked high", ADDR_HIGH, 32'h00000000);
    rdchk("unlocked low", ADDR_LOW, 32'h00000006);
    wr(ADDR_HIGH, UNLOCK_KEY_FIRST);
    rdchk("status key seen", ADDR_STAT, 32'h00000003);
    wr(ADDR_HIGH, UNLOCK_KEY_SECOND);
    wr(ADDR_LOW, 8'h77);
    refresh;
    rdchk("key high", ADDR_HIGH, 32'h00000000);
    rdchk("order low", ADDR_LOW, 32'h00000006);
    $display("test unlock done");
    rcOscEnable <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      timeoutResponseSelect <= i[0];
      stopMode <= i[1];
      refresh;
      wait_event;
      check("response", ev, expEv[i]);
      check("time-out span", n >= 40 && n <= 80, 1'b1);
      wait_event;
      check("second response", ev, expEv[i]);
    end
    $display("test responses done");
    onChipDebugger <= 1'b1;
    wait_event;
    check("debug quiet", ev, 5'h00);
    onChipDebugger <= 1'b0;
    rcOscEnable <= 1'b0;
    refresh;
    wait_event;
    check("oscillator off quiet", ev, 5'h00);
    $display("test quiet done");
    ce <= 1'b0;
    rcOscEnable <= 1'b1;
    repeat (230) @(posedge clk);
    ce <= 1'b1;
    rcOscEnable <= 1'b0;
    rdchk("frozen count", ADDR_LOW, 32'h00000006);
    $display("test clock enable done");
    reset_n <= 1'b0;
    alwaysOnOption <= 1'b1;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    check("always on", enabled, 1'b1);
    rdchk("count after reset", ADDR_HIGH, 32'h00000004);
    $display("test always on done");
    give_verdict;
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    give_verdict;
  end
endmodule

`default_nettype wire
